// *** verilog/bbi_consts.vh ***
// Constants of the two-wire target register access block
`ifndef BBI_CONSTS_VH
`define BBI_CONSTS_VH
`define BBI_ADDR_BASE      7'h35
`define BBI_ADDR_LOW       7'h6A
`define BBI_ADDR_HIGH      7'h6B
`define BBI_CLK_HZ         20000000
`define BBI_MAX_BIT_HZ     1000000
`define BBI_PTR_RESET      8'h00
`define BBI_FIFO_DEPTH     4
`define BBI_FIFO_WIDTH     16
`endif

// *** verilog/bbi_sync.v ***
// Two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module bbi_sync
(
	core_clk,
	rst,
	pin_in,
	pin_sync
);
	parameter RESET_VAL = 1'b1;
	input  wire core_clk;
	input  wire rst;
	input  wire pin_in;
	output wire pin_sync;

	reg         meta_q;
	reg         sync_q;

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign pin_sync = sync_q;
endmodule // bbi_sync

// *** verilog/bbi_fifo.v ***
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bbi_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW    = 2
)
(
	input  wire             core_clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_q;
	reg  [AW-1:0]    rd_q;
	reg  [AW:0]      cnt_q;
	wire             push;
	wire             pop;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge core_clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
		if (rst)
		begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // bbi_fifo

// *** verilog/bbi_target.v ***
// Two-wire bus target giving register access to a byte-wide register file
`timescale 1ns/1ps
`include "bbi_consts.vh"
module bbi_target #(
	parameter FIFO_DEPTH = `BBI_FIFO_DEPTH
)
(
	core_clk,
	rst,
	scl_in,
	sda_in,
	sda_out,
	sda_oe,
	address_select_pin,
	boot_busy,
	wr_data,
	wr_addr,
	wr_valid,
	wr_ready,
	rd_addr,
	rd_data,
	busy
);
	input  wire       core_clk;
	input  wire       rst;
	input  wire       scl_in;
	input  wire       sda_in;
	output wire       sda_out;
	output wire       sda_oe;
	input  wire       address_select_pin;
	input  wire       boot_busy;
	output wire [7:0] wr_data;
	output wire [7:0] wr_addr;
	output wire       wr_valid;
	input  wire       wr_ready;
	output wire [7:0] rd_addr;
	input  wire [7:0] rd_data;
	output wire       busy;

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	localparam ST_IDLE  = 3'd0;
	localparam ST_ADDR  = 3'd1;
	localparam ST_REG   = 3'd2;
	localparam ST_WDATA = 3'd3;
	localparam ST_RDATA = 3'd4;
	localparam ST_MACK  = 3'd5;
	localparam ST_IGN   = 3'd6;

	// Sampling at 20 MHz gives 20 samples per bit at the fastest rate
	localparam integer SAMPLES_PER_BIT = `BBI_CLK_HZ / `BBI_MAX_BIT_HZ;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	wire       scl_s;
	wire       sda_s;
	wire       sel_s;
	reg        scl_q;
	reg        sda_q;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_det;
	wire       stop_det;

	bbi_sync #(.RESET_VAL(1'b1)) u_sync_scl
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (scl_in),
		.pin_sync (scl_s)
	);

	bbi_sync #(.RESET_VAL(1'b1)) u_sync_sda
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (sda_in),
		.pin_sync (sda_s)
	);

	bbi_sync #(.RESET_VAL(1'b0)) u_sync_sel
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (address_select_pin),
		.pin_sync (sel_s)
	);

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Edges found on the core clock; sampling margin covers every rate
	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign start_det = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// ---------------------------------------------------------------
	// Write FIFO between the bus and the register file
	// ---------------------------------------------------------------
	reg        push_q;
	reg  [7:0] push_addr_q;
	reg  [7:0] push_data_q;
	wire       fifo_in_ready;

	bbi_fifo #(.WIDTH(`BBI_FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo
	(
		.core_clk  (core_clk),
		.rst       (rst),
		.in_data   ({push_addr_q, push_data_q}),
		.in_valid  (push_q),
		.in_ready  (fifo_in_ready),
		.out_data  ({wr_addr, wr_data}),
		.out_valid (wr_valid),
		.out_ready (wr_ready)
	);

	// ---------------------------------------------------------------
	// Byte engine
	// ---------------------------------------------------------------
	reg  [2:0] state_q;
	reg  [3:0] bit_q;
	reg  [7:0] shift_q;
	reg  [7:0] ptr_q;
	reg        ack_q;
	reg        drive_q;
	reg        is_read_q;
	wire [6:0] own_addr;
	wire       in_ack;

	assign own_addr = sel_s ? `BBI_ADDR_HIGH : `BBI_ADDR_LOW;
	assign in_ack   = (bit_q == 4'd8);
	assign rd_addr  = ptr_q;
	assign busy     = (state_q != ST_IDLE) && (state_q != ST_IGN);

	// Open drain: only ever pull low, never touch the clock line
	assign sda_out = 1'b0;
	assign sda_oe  = drive_q;

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q     <= ST_IDLE;
			bit_q       <= 4'd0;
			shift_q     <= 8'h00;
			ptr_q       <= `BBI_PTR_RESET;
			ack_q       <= 1'b0;
			drive_q     <= 1'b0;
			is_read_q   <= 1'b0;
			push_q      <= 1'b0;
			push_addr_q <= 8'h00;
			push_data_q <= 8'h00;
		end
		else
		begin
			push_q <= 1'b0;
			if (stop_det)
			begin
				state_q <= ST_IDLE;
				drive_q <= 1'b0;
				ack_q   <= 1'b0;
			end
			else if (start_det)
			begin
				state_q <= ST_ADDR;
				bit_q   <= 4'd0;
				drive_q <= 1'b0;
				ack_q   <= 1'b0;
			end
			else if (scl_rise && state_q != ST_IDLE && state_q != ST_IGN && state_q != ST_RDATA && !in_ack)
			begin
				// Data sampled on rising edge, MSB first
				shift_q <= {shift_q[6:0], sda_s};
				bit_q   <= bit_q + 4'd1;
			end
			else if (scl_rise && in_ack && state_q == ST_RDATA)
			begin
				// Controller ack or nack in ninth clock
				state_q <= sda_s ? ST_IGN : ST_MACK;
				// Advance now so the next register has settled by the falling edge
				if (!sda_s)
					ptr_q <= ptr_q + 8'd1;
			end
			else if (scl_fall && state_q != ST_IDLE && state_q != ST_IGN)
			begin
				if (bit_q == 4'd8 && !in_ack_done(state_q))
				begin
					// Ninth clock period: decide the acknowledge
					bit_q   <= 4'd8;
					drive_q <= 1'b0;
					case (state_q)
					ST_ADDR:
					begin
						// Match and not booting
						if (shift_q[7:1] == own_addr && !boot_busy)
						begin
							ack_q     <= 1'b1;
							drive_q   <= 1'b1;
							is_read_q <= shift_q[0];
						end
						else
							state_q <= ST_IGN;
					end
					ST_REG,
					ST_WDATA:
					begin
						// A full FIFO refuses the byte, as a busy device would
						if (!boot_busy && (state_q == ST_REG || fifo_in_ready))
						begin
							ack_q   <= 1'b1;
							drive_q <= 1'b1;
						end
						else
							state_q <= ST_IGN;
					end
					default:
						state_q <= ST_IGN;
					endcase
				end
				else if (in_ack && ack_q)
				begin
					// End of ack clock: release and move on
					ack_q   <= 1'b0;
					bit_q   <= 4'd0;
					drive_q <= 1'b0;
					case (state_q)
					ST_ADDR:
					begin
						if (is_read_q)
						begin
							state_q <= ST_RDATA;
							shift_q <= rd_data;
							drive_q <= ~rd_data[7];
						end
						else
							state_q <= ST_REG;
					end
					ST_REG:
					begin
						ptr_q   <= shift_q;
						state_q <= ST_WDATA;
					end
					ST_WDATA:
					begin
						push_q      <= 1'b1;
						push_addr_q <= ptr_q;
						push_data_q <= shift_q;
						ptr_q       <= ptr_q + 8'd1;
					end
					default:
						state_q <= ST_IGN;
					endcase
				end
				else if (state_q == ST_RDATA && bit_q < 4'd8)
				begin
					// Shift out next bit after each falling edge, MSB first
					shift_q <= {shift_q[6:0], 1'b1};
					bit_q   <= bit_q + 4'd1;
					drive_q <= (bit_q == 4'd7) ? 1'b0 : ~shift_q[6];
				end
				else if (state_q == ST_RDATA && in_ack)
					drive_q <= 1'b0;
				else if (state_q == ST_MACK)
				begin
					// Acked read byte: next register, first bit out
					bit_q   <= 4'd0;
					state_q <= ST_RDATA;
					shift_q <= rd_data;
					drive_q <= ~rd_data[7];
				end
			end
		end
	end

	// Ack decision happens once; read states never take one, the controller acks there
	function in_ack_done;
		input [2:0] st;
		begin
			in_ack_done = ack_q | (st == ST_RDATA) | (st == ST_MACK);
		end
	endfunction
endmodule // bbi_target

// *** test/bbi_chk_checker.sv ***
// Checker of the two-wire target pins and write queue
`timescale 1ns/1ps
module bbi_chk
(
	input wire       core_clk,
	input wire       rst,
	input wire       scl_in,
	input wire       sda_in,
	input wire       sda_out,
	input wire       sda_oe,
	input wire       boot_busy,
	input wire [7:0] wr_data,
	input wire [7:0] wr_addr,
	input wire       wr_valid,
	input wire       wr_ready,
	input wire       busy
);
	// ----
	// Properties
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	open_drain_a: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	sda_change_a: assert property ($changed(sda_oe) |-> !$past(scl_in))
		else $error("data drive changed with clock high");
	boot_nack_a: assert property ($rose(sda_oe) |-> !$past(boot_busy, 4))
		else $error("drive while booting");
	idle_quiet_a: assert property (!busy && !$past(busy) |-> !sda_oe)
		else $error("drive while idle");
	ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
		else $error("drive shorter than a bit");
	queue_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
		else $error("queue head moved while stalled");
	start_busy_a: assert property ($fell(sda_in) && scl_in && !boot_busy |-> ##[1:6] busy)
		else $error("start not seen");
	stop_end_a: assert property ($rose(sda_in) && scl_in |-> ##[1:8] !busy)
		else $error("stop did not end transfer");
endmodule // bbi_chk
bind bbi_target bbi_chk u_bbi_chk (.*);

// *** test/bbi_ctrl.sv ***
// Bus controller model driving the clock and data lines
`timescale 1ns/1ps
module bbi_ctrl
(
	input  wire core_clk,
	input  wire dev_oe,
	output wire scl,
	output wire sda
);
	// ----
	// Line drive
	// ----
	reg scl_q = 1'b1;
	reg low_q = 1'b0;
	assign scl = scl_q;
	// Pull-up gives the high level
	assign sda = !(low_q || dev_oe);
	task cyc(input integer n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Data moves mid low phase, sampled late in high phase
	task bt(input b, output s);
		scl_q = 1'b0;
		cyc(2);
		low_q = !b;
		cyc(2);
		scl_q = 1'b1;
		cyc(3);
		s = sda;
		cyc(1);
	endtask
	task st;
		scl_q = 1'b0;
		cyc(2);
		low_q = 1'b0;
		cyc(2);
		scl_q = 1'b1;
		cyc(4);
		low_q = 1'b1;
		cyc(4);
	endtask
	task sp;
		scl_q = 1'b0;
		cyc(2);
		low_q = 1'b1;
		cyc(2);
		scl_q = 1'b1;
		cyc(4);
		low_q = 1'b0;
		cyc(4);
	endtask
	// Eight bits then the ninth for acknowledge
	task x(input [8:0] d, output [8:0] q);
		integer i;
		for (i = 8; i >= 0; i--)
			bt(d[i], q[i]);
	endtask
endmodule // bbi_ctrl

// *** test/bbi_target_bench.sv ***
// Self-checking bench of the two-wire target
`timescale 1ns/1ps
module bbi_target_bench;
	// ----
	// Wiring
	// ----
	logic       core_clk, rst, sel, boot, wr_ready;
	wire        scl, sda, sda_out, sda_oe, wr_valid, busy;
	wire  [7:0] wr_data, wr_addr, rd_addr;
	wire  [7:0] rd_data = rd_addr ^ 8'hA5;
	integer     fail_count = 0;
	integer     compares = 0;
	bbi_target u_bbi_target (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .address_select_pin(sel), .boot_busy(boot), .wr_data(wr_data), .wr_addr(wr_addr),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
	bbi_ctrl u_bbi_ctrl (.core_clk(core_clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ----
	// Tasks
	// ----
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task hdr(input [6:0] a, input r, input e);
		logic [8:0] q;
		u_bbi_ctrl.st;
		u_bbi_ctrl.x({a, r, 1'b1}, q);
		chk("address ack", q[0], e);
	endtask
	// Stalled queue refuses the fifth byte, then drains in order
	task t_write;
		logic [8:0] q;
		integer i;
		hdr(7'h6A, 1'b0, 1'b0);
		u_bbi_ctrl.x({8'h10, 1'b1}, q);
		chk("index ack", q[0], 1'b0);
		for (i = 0; i < 5; i++)
		begin
			u_bbi_ctrl.x({8'h30 + i[7:0], 1'b1}, q);
			chk("data ack", q[0], i == 4);
		end
		u_bbi_ctrl.sp;
		chk("busy after stop", busy, 1'b0);
		chk("pointer", rd_addr, 8'h14);
		wr_ready = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			chk("head index", wr_addr, 8'h10 + i[7:0]);
			chk("head data", wr_data, 8'h30 + i[7:0]);
			u_bbi_ctrl.cyc(1);
		end
		chk("drained", wr_valid, 1'b0);
	endtask
	// Sequential read across the pointer wrap
	task t_read;
		logic [8:0] q;
		integer i;
		hdr(7'h6A, 1'b0, 1'b0);
		u_bbi_ctrl.x({8'hFE, 1'b1}, q);
		hdr(7'h6A, 1'b1, 1'b0);
		for (i = 0; i < 3; i++)
		begin
			u_bbi_ctrl.x({8'hFF, i == 2}, q);
			chk("read data", q[8:1], (8'hFE + i[7:0]) ^ 8'hA5);
		end
		u_bbi_ctrl.sp;
	endtask
	task t_addr;
		logic [8:0] q;
		sel = 1'b1;
		hdr(7'h6A, 1'b0, 1'b1);
		u_bbi_ctrl.sp;
		hdr(7'h6B, 1'b0, 1'b0);
		u_bbi_ctrl.sp;
		sel = 1'b0;
		hdr(7'h6B, 1'b0, 1'b1);
		u_bbi_ctrl.x({8'h00, 1'b1}, q);
		chk("ignored byte", q[0], 1'b1);
		u_bbi_ctrl.sp;
		boot = 1'b1;
		hdr(7'h6A, 1'b0, 1'b1);
		u_bbi_ctrl.sp;
		boot = 1'b0;
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		rst = 1'b1;
		sel = 1'b0;
		boot = 1'b0;
		wr_ready = 1'b0;
		u_bbi_ctrl.cyc(20);
		rst = 1'b0;
		u_bbi_ctrl.cyc(4);
		t_write;
		t_read;
		t_addr;
		end_of_test;
	end
	// Run needs about 74 us
	initial
	begin
		#2_000_000;
		fail_count++;
		end_of_test;
	end
endmodule // bbi_target_bench
